// File: smc_pkg.sv
// package for the static memory port controller: types, field layouts, reset values
package smc_pkg;

  // bank configuration field layout (16-bit register image)
  localparam int unsigned BLEN_LSB  = 8;
  localparam int unsigned BLEN_W    = 7;
  localparam int unsigned EREN_BIT  = 7;
  localparam int unsigned ISYN_BIT  = 6;
  localparam int unsigned BEN_BIT   = 5;
  localparam int unsigned CLEN_LSB  = 2;
  localparam int unsigned CLEN_W    = 3;

  // reset values of the bank configuration registers and second bank base
  localparam logic [15:0] BANK0_CFG_RST = 16'h7f3d;
  localparam logic [15:0] BANK1_CFG_RST = 16'h0001;
  localparam logic [15:0] BASE1_RST     = 16'h0000;

  // address geometry
  localparam int unsigned EXT_ADDR_W   = 22;  // external address lines carry ahb bits 22:1
  localparam int unsigned SPACE_MSB    = 22;  // 8 MB space
  localparam int unsigned LEN_LSB      = 16;  // bank size granule 64 KB
  localparam int unsigned BASE_LSB     = 11;  // base granule 2 KB
  localparam int unsigned BASE_FIELD_W = 12;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_BYTE    = 3'h0;
  localparam logic [2:0] HSIZE_HALF    = 3'h1;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;
  localparam logic [1:0] HRESP_ERROR   = 2'h1;

  typedef enum logic [2:0] {
    SMC_IDLE   = 3'b000,
    SMC_ACTIVE = 3'b001,
    SMC_HOLD   = 3'b010,
    SMC_ERR1   = 3'b011,
    SMC_ERR2   = 3'b100
  } smc_state_t;

  // per-bank settings decoded from a configuration word
  typedef struct packed {
    logic [6:0] blen;
    logic       eren;
    logic       isyn;
    logic       en;
    logic [2:0] clen;
  } smc_bank_cfg_t;

  // external memory pins
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] wdata;
    logic        wdata_oe;
    logic        cs_first_n;
    logic        cs_second_n;
    logic        read_strobe_n;
    logic [1:0]  byte_we_n;
  } smc_ext_out_t;

endpackage : smc_pkg

// File: smc_bank_decode.sv
// one bank's address window check and configuration unpacking
`timescale 1ns/100ps
module smc_bank_decode #(
  parameter bit HAS_BASE = 1'b0
) (
  // configuration
  input  wire logic [15:0]            cfg_word,
  input  wire logic [15:0]            base_word,
  // address under test
  input  wire logic [31:0]            haddr,
  // result
  output smc_pkg::smc_bank_cfg_t      cfg,
  output logic                        hit
);
  import smc_pkg::*;

  logic [SPACE_MSB:0] start_addr;
  logic [SPACE_MSB:0] offset;
  logic [SPACE_MSB:0] span;

  always_comb begin
    cfg.blen = cfg_word[BLEN_LSB +: BLEN_W];
    cfg.eren = cfg_word[EREN_BIT];
    cfg.isyn = cfg_word[ISYN_BIT];
    cfg.en   = cfg_word[BEN_BIT];
    cfg.clen = cfg_word[CLEN_LSB +: CLEN_W];
    // base: 12 field bits then eleven zeros; first bank fixed at zero
    start_addr = HAS_BASE ? {base_word[BASE_FIELD_W-1:0], 11'h000} : 23'h000000;
    offset     = haddr[SPACE_MSB:0] - start_addr;
    // size is (blen+1) * 64 KB
    span       = {cfg.blen, 16'h0000} + 23'h010000;
    // offset compare wraps inside the 8 MB space; a full 8 MB span wraps to zero
    hit = (haddr[31:SPACE_MSB+1] == 9'h000) && ((cfg.blen == 7'h7f) || (offset < span));
  end

endmodule : smc_bank_decode

// File: smc_static_memory_port.sv
// ahb to 16-bit external static memory controller with two chip-select banks
`timescale 1ns/100ps
module smc_static_memory_port (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  // ahb slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready_in,
  output logic [31:0]                 hrdata,
  output logic                        hready_out,
  output logic [1:0]                  hresp,
  // configuration, held by the peripheral bus block
  input  wire logic [15:0]            bank_config_register_0,
  input  wire logic [15:0]            bank_config_register_1,
  input  wire logic [15:0]            second_bank_base,
  // external memory
  output smc_pkg::smc_ext_out_t       ext_out,
  input  wire logic [15:0]            ext_rdata,
  input  wire logic                   ext_ready
);
  import smc_pkg::*;

  typedef struct packed {
    smc_state_t   state;
    logic         bank;       // 0 first, 1 second
    logic         write;
    logic [2:0]   size;
    logic [31:0]  addr;
    logic [31:0]  rdata;
    logic [15:0]  wdata;
    logic [3:0]   count;
    logic         second;     // on the high half of a word access
    logic         data_ph;    // write data must still be captured from hwdata
    logic         rdy_s1;
    logic         rdy_s2;
    logic         rdy_q;
    smc_ext_out_t ext;
    logic         ready;
    logic [1:0]   resp;
  } smc_regs_t;

  smc_regs_t     r;
  smc_regs_t     next_r;
  smc_bank_cfg_t cfg0;
  smc_bank_cfg_t cfg1;
  smc_bank_cfg_t cur;
  logic          hit0;
  logic          hit1;
  logic          take;
  logic          rdy_sel;
  logic          end_ok;
  logic [1:0]    lane_we_n;

  smc_bank_decode #(.HAS_BASE(1'b0)) u_bank0 (
    .cfg_word  (bank_config_register_0),
    .base_word (16'h0000),
    .haddr     (haddr),
    .cfg       (cfg0),
    .hit       (hit0)
  );

  smc_bank_decode #(.HAS_BASE(1'b1)) u_bank1 (
    .cfg_word  (bank_config_register_1),
    .base_word (second_bank_base),
    .haddr     (haddr),
    .cfg       (cfg1),
    .hit       (hit1)
  );

  assign cur        = r.bank ? cfg1 : cfg0;
  assign hready_out = r.ready;
  assign hresp      = r.resp;
  assign hrdata     = r.rdata;
  assign ext_out    = r.ext;

  always_comb begin
    next_r    = r;
    take      = hsel && hready_in && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    // synchronised ready uses the two-stage copy, otherwise the raw pin is sampled once
    rdy_sel   = cur.isyn ? r.rdy_s2 : r.rdy_q;
    // wait states first, then ready if enabled
    end_ok    = (r.count == 4'h0) && (!cur.eren || rdy_sel);
    lane_we_n = 2'b11;

    next_r.rdy_s1 = ext_ready;
    next_r.rdy_s2 = r.rdy_s1;
    next_r.rdy_q  = ext_ready;

    case (r.state)
      SMC_IDLE: begin
        next_r.ready = 1'b1;
        next_r.resp  = HRESP_OKAY;
        if (take) begin
          next_r.write   = hwrite;
          next_r.size    = hsize;
          next_r.addr    = haddr;
          next_r.second  = 1'b0;
          next_r.data_ph = hwrite;
          next_r.ready   = 1'b0;
          if (hit0 && cfg0.en) begin
            next_r.bank = 1'b0;
          end else if (hit1 && cfg1.en) begin
            next_r.bank = 1'b1;
          end else begin
            // unmapped or disabled: no strobe, two-cycle error answer
            next_r.state = SMC_ERR1;
          end
          if ((hit0 && cfg0.en) || (hit1 && cfg1.en)) begin
            next_r.state             = SMC_ACTIVE;
            // reads count one clock more: read strobe spans wait+2, write strobe wait+1
            next_r.count             = {1'b0, ((hit0 && cfg0.en) ? cfg0.clen : cfg1.clen)}
                                       + {3'h0, !hwrite};
            // word access starts on the low halfword
            next_r.ext.addr          = {haddr[SPACE_MSB:2], haddr[1] & (hsize != HSIZE_WORD)};
            // a write opens its select together with the strobes: no setup clock
            next_r.ext.cs_first_n    = !(hit0 && cfg0.en) || hwrite;
            next_r.ext.cs_second_n   = (hit0 && cfg0.en) || hwrite;
            next_r.ext.read_strobe_n = hwrite;
            next_r.ext.byte_we_n     = 2'b11;
          end
        end
      end
      SMC_ACTIVE: begin
        if (r.data_ph) begin
          // write data arrives in the ahb data phase; strobes open with it
          next_r.data_ph      = 1'b0;
          next_r.wdata        = hwdata[31:16];
          next_r.ext.wdata    = (r.size == HSIZE_WORD || !r.addr[1]) ? hwdata[15:0]
                                                                    : hwdata[31:16];
          next_r.ext.wdata_oe = 1'b1;
          next_r.ext.cs_first_n  = r.bank;
          next_r.ext.cs_second_n = !r.bank;
          if (r.size == HSIZE_BYTE) begin
            lane_we_n[r.addr[0]] = 1'b0;
          end else begin
            lane_we_n = 2'b00;
          end
          next_r.ext.byte_we_n = lane_we_n;
        end else if (end_ok) begin
          if (!r.write && !r.second) begin
            // low half sampled at the last strobe clock, wait+2 after its address
            next_r.rdata = {ext_rdata, ext_rdata};
          end
          if (r.write) begin
            next_r.ext.byte_we_n = 2'b11;
            next_r.state         = SMC_HOLD;
          end else if (r.size == HSIZE_WORD && !r.second) begin
            // select stays low, only address line zero moves
            next_r.second          = 1'b1;
            next_r.ext.addr[0]     = 1'b1;
            // high half is sampled one clock before its select time ends
            next_r.count           = {1'b0, cur.clen} + 4'h1;
          end else begin
            next_r.ext.cs_first_n    = 1'b1;
            next_r.ext.cs_second_n   = 1'b1;
            next_r.ext.read_strobe_n = 1'b1;
            next_r.ready             = 1'b1;
            next_r.state             = SMC_IDLE;
          end
        end else if (r.count != 4'h0) begin
          if (!r.write && r.second) begin
            // last capture falls wait+1 clocks after the high address
            next_r.rdata[31:16] = ext_rdata;
          end
          next_r.count = r.count - 4'h1;
        end
      end
      SMC_HOLD: begin
        // one hold clock with select low and data driven
        if (r.size == HSIZE_WORD && !r.second) begin
          next_r.second         = 1'b1;
          next_r.ext.addr[0]    = 1'b1;
          next_r.ext.wdata      = r.wdata;
          next_r.ext.byte_we_n  = 2'b00;
          next_r.count          = {1'b0, cur.clen};
          next_r.state          = SMC_ACTIVE;
        end else begin
          next_r.ext.cs_first_n  = 1'b1;
          next_r.ext.cs_second_n = 1'b1;
          next_r.ext.wdata_oe    = 1'b0;
          next_r.ready           = 1'b1;
          next_r.resp            = HRESP_OKAY;
          next_r.state           = SMC_IDLE;
        end
      end
      SMC_ERR1: begin
        next_r.resp  = HRESP_ERROR;
        next_r.state = SMC_ERR2;
      end
      SMC_ERR2: begin
        next_r.ready = 1'b1;
        next_r.state = SMC_IDLE;
      end
      default: begin
        next_r.state = SMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r                   <= '0;
      r.state             <= SMC_IDLE;
      r.ready             <= 1'b1;
      r.resp              <= HRESP_OKAY;
      r.ext.cs_first_n    <= 1'b1;
      r.ext.cs_second_n   <= 1'b1;
      r.ext.read_strobe_n <= 1'b1;
      r.ext.byte_we_n     <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

endmodule : smc_static_memory_port

// File: smc_checker.sv
// pin and handshake checks for the static memory port
`timescale 1ns/100ps
module smc_checker (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst_b,
  // ahb
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hready_in,
  input wire logic                  hready_out,
  input wire logic [1:0]            hresp,
  // configuration and pins
  input wire logic [15:0]           bank_config_register_0,
  input wire logic [15:0]           bank_config_register_1,
  input wire smc_pkg::smc_ext_out_t ext_out
);
  import smc_pkg::*;
  logic [15:0] cfg;
  logic [4:0]  n_rd, n_we, len;
  logic        eren;
  wire         cs_lo = !(ext_out.cs_first_n && ext_out.cs_second_n);
  wire         rd_lo = !ext_out.read_strobe_n;
  wire         we_lo = ext_out.byte_we_n != 2'h3;
  assign cfg = ext_out.cs_first_n ? bank_config_register_1 : bank_config_register_0;
  // settings latched while selected: select may drop in the same cycle as the strobe
  always_ff @(posedge core_clk) begin
    n_rd <= (rst_b && rd_lo) ? n_rd + 5'h1 : 5'h0;
    n_we <= (rst_b && we_lo) ? n_we + 5'h1 : 5'h0;
    if (cs_lo) begin
      len  <= {2'h0, cfg[CLEN_LSB +: CLEN_W]};
      eren <= cfg[EREN_BIT];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    hsel && hready_in && htrans[1] && hready_out;
  endsequence
  sequence s_rd_end;
    $rose(ext_out.read_strobe_n) && !eren;
  endsequence
  chk_take_wait: assert property (s_take |=> !hready_out)
    else $error("no wait state");
  chk_busy_select: assert property (cs_lo |-> !hready_out)
    else $error("ready during select");
  chk_read_len: assert property (s_rd_end |-> n_rd == len + 5'h2 || n_rd == 5'h2 * (len + 5'h2))
    else $error("read strobe length");
  chk_write_len: assert property ($fell(we_lo) && !eren |-> n_we == len + 5'h1)
    else $error("write strobe length");
  chk_write_hold: assert property ($fell(we_lo) |-> cs_lo)
    else $error("no write hold");
  chk_one_select: assert property (ext_out.cs_first_n || ext_out.cs_second_n)
    else $error("both selects low");
  chk_strobe_select: assert property (rd_lo || we_lo |-> cs_lo)
    else $error("strobe without select");
  chk_select_setup: assert property ($rose(cs_lo) |-> rd_lo || we_lo)
    else $error("select opened before strobe");
  chk_read_write: assert property (!(rd_lo && we_lo))
    else $error("read and write strobes");
  chk_error_idle: assert property (hresp == HRESP_ERROR |-> !cs_lo)
    else $error("select on error");
  chk_addr_hold: assert property (rd_lo && $past(rd_lo) |-> $stable(ext_out.addr[21:1]))
    else $error("address moved");
endmodule : smc_checker

// File: smc_sram_model.sv
// behavioural static memory behind the port
`timescale 1ns/100ps
module smc_sram_model (
  // clock
  input  wire logic                  core_clk,
  // pins and pacing
  input  wire smc_pkg::smc_ext_out_t ext_out,
  input  wire logic [3:0]            lat,
  output logic [15:0]                ext_rdata,
  output logic                       ext_ready
);
  import smc_pkg::*;
  logic [15:0] mem [0:4095];
  logic [15:0] last = 16'h0;
  logic [3:0]  n = 4'h0;
  wire         sel = !(ext_out.cs_first_n && ext_out.cs_second_n);
  // off the bus the lines toggle so a sample one clock late never matches
  assign ext_rdata = (sel && !ext_out.read_strobe_n) ? mem[ext_out.addr[11:0]] : ~last;
  assign ext_ready = sel && n >= lat;
  always @(posedge core_clk) begin
    last <= ext_rdata;
    n <= sel ? n + {3'h0, n != 4'hf} : 4'h0;
    for (int b = 0; b < 2; b++) begin
      if (sel && !ext_out.byte_we_n[b]) begin
        mem[ext_out.addr[11:0]][b*8 +: 8] <= ext_out.wdata[b*8 +: 8];
      end
    end
  end
endmodule : smc_sram_model

// File: smc_static_memory_port_tb.sv
// self-checking bench: ahb transfers through the port into a memory model
`timescale 1ns/100ps
module smc_static_memory_port_tb;
  import smc_pkg::*;
  typedef struct packed {
    logic        rd;
    logic [31:0] m;
    logic [31:0] d;
    logic [1:0]  r;
  } smc_exp_t;
  logic         core_clk, rst_b, hsel, hwrite, hready_out, ext_ready;
  logic         pend = 1'b0;
  logic [31:0]  haddr, hwdata, hrdata, d;
  logic [1:0]   htrans, hresp;
  logic [2:0]   hsize;
  logic [15:0]  cfg0, cfg1, base1, ext_rdata;
  logic [3:0]   lat;
  smc_ext_out_t ext_out;
  smc_exp_t     q[$];
  smc_exp_t     e;
  int           failures = 0, samples_checked = 0, cyc = 0, t = 0;
  smc_static_memory_port dut (
    .core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready_in(1'b1),
    .hrdata, .hready_out, .hresp, .bank_config_register_0(cfg0),
    .bank_config_register_1(cfg1), .second_bank_base(base1), .ext_out, .ext_rdata, .ext_ready
  );
  smc_sram_model sram (.core_clk, .ext_out, .lat, .ext_rdata, .ext_ready);
  function automatic logic [15:0] mk(input logic [6:0] b, input logic r, n, input logic [2:0] c);
    return {1'b0, b, r, r, n, c, 2'h1};
  endfunction : mk
  task automatic cmp_data(input logic [31:0] x, y);
    samples_checked++;
    if (x !== y) begin
      failures++;
      $display("[ERR] hrdata exp %h got %h", x, y);
    end
  endtask : cmp_data
  task automatic cmp_resp(input logic [1:0] x, y);
    samples_checked++;
    if (x !== y) begin
      failures++;
      $display("[ERR] hresp exp %h got %h", x, y);
    end
  endtask : cmp_resp
  task automatic end_of_test;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // request held until the edge that samples ready high
  task automatic xfer(input logic w, input logic [2:0] s, input logic [31:0] a, wd, m, x,
                      input logic [1:0] r);
    @(negedge core_clk);
    hsel = 1'b1;
    htrans = HTRANS_NONSEQ;
    hwrite = w;
    hsize = s;
    haddr = a;
    @(posedge core_clk);
    while (!hready_out) @(posedge core_clk);
    q.push_back('{!w, m, x, r});
    @(negedge core_clk);
    hsel = 1'b0;
    htrans = 2'h0;
    hwdata = wd;
  endtask : xfer
  task automatic next_test;
    while (!hready_out) @(negedge core_clk);
    $display("test %0d done", t);
    t++;
  endtask : next_test
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_of_test;
    end
    if (pend && hready_out) begin
      e = q.pop_front();
      cmp_resp(e.r, hresp);
      if (e.rd) cmp_data(e.d & e.m, hrdata & e.m);
      pend = 1'b0;
    end
    if (rst_b && hsel && htrans[1] && hready_out) pend = 1'b1;
  end
  initial begin
    {rst_b, hsel, hwrite, htrans, hsize, haddr, hwdata, lat} = '0;
    cfg0 = mk(7'h0, 1'b0, 1'b1, 3'h0);
    cfg1 = mk(7'h0, 1'b0, 1'b1, 3'h1);
    base1 = 16'h0040;
    void'($urandom(32'haa16ec75));
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    for (int c = 0; c < 8; c++) begin
      cfg0 = mk(7'h0, 1'b0, 1'b1, c[2:0]);
      d = $urandom;
      xfer(1'b1, HSIZE_HALF, 32'h8 * c, d, 0, 0, HRESP_OKAY);
      xfer(1'b0, HSIZE_HALF, 32'h8 * c, 0, 32'hffff, d, HRESP_OKAY);
      xfer(1'b1, HSIZE_WORD, 32'h100 + 32'h8 * c, d, 0, 0, HRESP_OKAY);
      xfer(1'b0, HSIZE_WORD, 32'h100 + 32'h8 * c, 0, '1, d, HRESP_OKAY);
      next_test;
    end
    d = $urandom;
    xfer(1'b1, HSIZE_BYTE, 32'h201, {4{d[15:8]}}, 0, 0, HRESP_OKAY);
    xfer(1'b1, HSIZE_BYTE, 32'h200, {4{d[7:0]}}, 0, 0, HRESP_OKAY);
    xfer(1'b0, HSIZE_HALF, 32'h200, 0, 32'hffff, d, HRESP_OKAY);
    xfer(1'b1, HSIZE_HALF, 32'h20010, d, 0, 0, HRESP_OKAY);
    next_test;
    cfg0 = mk(7'h1, 1'b0, 1'b1, 3'h0);
    xfer(1'b0, HSIZE_HALF, 32'h10010, 0, 32'hffff, d, HRESP_OKAY);
    xfer(1'b1, HSIZE_HALF, 32'h30000, 0, 0, 0, HRESP_ERROR);
    next_test;
    cfg1 = mk(7'h0, 1'b0, 1'b0, 3'h1);
    xfer(1'b0, HSIZE_HALF, 32'h20010, 0, 0, 0, HRESP_ERROR);
    xfer(1'b0, HSIZE_WORD, 32'h80000000, 0, 0, 0, HRESP_ERROR);
    next_test;
    cfg0 = mk(7'h1, 1'b1, 1'b1, 3'h1);
    lat = 4'h5;
    d = $urandom;
    xfer(1'b1, HSIZE_WORD, 32'h300, d, 0, 0, HRESP_OKAY);
    xfer(1'b0, HSIZE_WORD, 32'h300, 0, '1, d, HRESP_OKAY);
    next_test;
    @(posedge core_clk);
    @(negedge core_clk);
    end_of_test;
  end
endmodule : smc_static_memory_port_tb
bind smc_static_memory_port smc_checker chk (.core_clk, .rst_b, .hsel, .htrans, .hready_in,
  .hready_out, .hresp, .bank_config_register_0, .bank_config_register_1, .ext_out);
